// [include/dpll_core_pkg.sv]
// constants and types shared by the dpll tuning and lock core
// Summary of operation
// RULE1: each error sample fills when magnitude is within threshold, else drains; sign ignored
// RULE2: lock asserts above +1024, clears below -1024, otherwise holds previous state
// RULE3: level spans -2048 to +2048 and saturates at both ends
// RULE4: fill and drain amounts are 8-bit unsigned profile values
// RULE5: phase threshold is a 16-bit unsigned picosecond magnitude
// RULE6: lock reads unlocked whenever free-run or holdover is entered
// RULE7: switchover freezes lock indication to avoid false unlock
// RULE8: frequency detector reuses the mechanism on period difference magnitude
// RULE9: frequency threshold is a 24-bit unsigned picosecond value
// RULE10: accumulator adds 48-bit step word every cycle modulo two to 48
// RULE11: 16-bit phase offset added to accumulator output, full range one cycle
// RULE12: software keeps output frequency above 62.5 MHz
// RULE13: step word from free-run register, loop filter, or history by mode
// RULE14: output limited between 24-bit upper and lower bounds in all modes
// RULE15: after reset bounds span zero to full rate, clamp inactive
// RULE16: averaging interval is 24-bit milliseconds, minimum 1 ms
// RULE17: software never programs averaging interval to zero
// RULE18: each interval end stores mean of that interval only into history
// RULE19: interval end strobe sets history event flag when its mask enabled
// RULE20: history strobe selectable onto multifunction pin output
// RULE21: clamp saturates using upper 24 bits, replacing word by violated bound
// RULE22: mean is full-width sum divided by sample count
package dpll_core_pkg;
  // register byte offsets
  localparam logic [11:0] FREE_RUN_STEP_WORD_ADDR     = 12'h300;
  localparam logic [11:0] FREQUENCY_CLAMP_BOUNDS_ADDR = 12'h307;
  localparam logic [11:0] OPEN_LOOP_PHASE_OFFSET_ADDR = 12'h30d;
  localparam logic [11:0] HISTORY_INTERVAL_MS_ADDR    = 12'h318;
  localparam logic [11:0] AVERAGED_STEP_WORD_ADDR     = 12'hd14;
  // register byte counts
  localparam logic [11:0] STEP_BYTES     = 12'h006;
  localparam logic [11:0] OFFSET_BYTES   = 12'h002;
  localparam logic [11:0] INTERVAL_BYTES = 12'h003;
  // reset values
  localparam logic [47:0] FREE_RUN_RESET    = 48'h0;
  localparam logic [23:0] CLAMP_LOWER_RESET = 24'h000000;
  localparam logic [23:0] CLAMP_UPPER_RESET = 24'hffffff;
  localparam logic [15:0] OFFSET_RESET      = 16'h0;
  localparam logic [23:0] INTERVAL_RESET    = 24'h000001;
  // lock detector levels
  localparam logic signed [13:0] LEVEL_FULL  = 14'sd2048;
  localparam logic signed [13:0] LEVEL_EMPTY = -14'sd2048;
  localparam logic signed [13:0] LEVEL_HIGH  = 14'sd1024;
  localparam logic signed [13:0] LEVEL_LOW   = -14'sd1024;
  // timing
  localparam int CLOCK_PERIOD_PS = 25000;
  localparam int MS_IN_PS        = 1000000000;
  localparam int CYCLES_PER_MS   = (MS_IN_PS + CLOCK_PERIOD_PS - 1) / CLOCK_PERIOD_PS;
  // loop operating modes from the loop controller
  typedef enum logic [1:0] {
    MODE_FREE_RUN,
    MODE_CLOSED_LOOP,
    MODE_HOLDOVER,
    MODE_SWITCHOVER
  } loop_mode_t;
  // active profile lock settings
  typedef struct packed {
    logic [7:0]  phase_fill;
    logic [7:0]  phase_drain;
    logic [15:0] phase_threshold;
    logic [7:0]  freq_fill;
    logic [7:0]  freq_drain;
    logic [23:0] freq_threshold;
  } lock_profile_t;
  // register access request
  typedef struct packed {
    logic        write;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } reg_req_t;
endpackage : dpll_core_pkg

// [logic/dpll_tuning_and_lock_core.sv]
// dpll lock detectors, synthesizer accumulator, clamp and history averager
`timescale 1ns/1ps
module dpll_tuning_and_lock_core #(
  parameter int CYCLES_PER_MS = dpll_core_pkg::CYCLES_PER_MS
) (
  // clock and control
  input  wire logic                       clock,
  input  wire logic                       reset_n,
  input  wire logic                       clock_en,
  // byte register port
  input  wire dpll_core_pkg::reg_req_t    reg_req,
  output logic [7:0]                      reg_rdata,
  // loop controller and loop filter
  input  wire dpll_core_pkg::loop_mode_t  loop_mode,
  input  wire logic [47:0]                loop_filter_word,
  input  wire dpll_core_pkg::lock_profile_t profile,
  // error samples
  input  wire logic                       phase_err_valid,
  input  wire logic signed [31:0]         phase_err,
  input  wire logic                       period_diff_valid,
  input  wire logic signed [31:0]         period_diff,
  // lock indications
  output logic                            phase_locked,
  output logic                            freq_locked,
  // synthesizer phase to the converter
  output logic [15:0]                     dds_phase,
  // history event and pin
  input  wire logic                       history_mask_en,
  input  wire logic                       history_flag_clear,
  input  wire logic                       history_pin_sel,
  output logic                            history_flag,
  output logic                            history_strobe,
  output logic                            history_pin
);
  logic [47:0] free_run_reg;
  logic [23:0] clamp_lower_reg;
  logic [23:0] clamp_upper_reg;
  logic [15:0] offset_reg;
  logic [23:0] interval_reg;
  logic [47:0] history_reg;
  logic [47:0] accum_reg;
  logic [15:0] phase_out_reg;
  logic [7:0]  rdata_reg;
  logic        flag_reg;
  logic [47:0] selected_word;
  logic [47:0] clamped_word;
  logic [11:0] rel;
  logic        open_mode;
  logic        lock_reg [2];

  // byte writes into the control registers
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      free_run_reg    <= dpll_core_pkg::FREE_RUN_RESET;
      clamp_lower_reg <= dpll_core_pkg::CLAMP_LOWER_RESET; // [RULE15]
      clamp_upper_reg <= dpll_core_pkg::CLAMP_UPPER_RESET; // [RULE15]
      offset_reg      <= dpll_core_pkg::OFFSET_RESET;
      interval_reg    <= dpll_core_pkg::INTERVAL_RESET;
    end else if (clock_en && reg_req.write) begin
      if (reg_req.addr >= dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR &&
          reg_req.addr < dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR + dpll_core_pkg::STEP_BYTES) begin
        free_run_reg[rel[2:0]*8 +: 8] <= reg_req.wdata;
      end else if (reg_req.addr >= dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR &&
          reg_req.addr < dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR + dpll_core_pkg::STEP_BYTES) begin
        if (rel < dpll_core_pkg::INTERVAL_BYTES) begin
          clamp_lower_reg[rel[1:0]*8 +: 8] <= reg_req.wdata; // [RULE14]
        end else begin
          clamp_upper_reg[2'(rel - 12'h3)*8 +: 8] <= reg_req.wdata; // [RULE14]
        end
      end else if (reg_req.addr >= dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR &&
          reg_req.addr < dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR + dpll_core_pkg::OFFSET_BYTES) begin
        offset_reg[rel[0]*8 +: 8] <= reg_req.wdata; // [RULE11]
      end else if (reg_req.addr >= dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR &&
          reg_req.addr < dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR + dpll_core_pkg::INTERVAL_BYTES) begin
        interval_reg[rel[1:0]*8 +: 8] <= reg_req.wdata; // [RULE16]
      end
    end
  end

  // offset of the address inside the decoded register
  always_comb begin
    rel = 12'h0;
    if (reg_req.addr >= dpll_core_pkg::AVERAGED_STEP_WORD_ADDR) begin
      rel = reg_req.addr - dpll_core_pkg::AVERAGED_STEP_WORD_ADDR;
    end else if (reg_req.addr >= dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR) begin
      rel = reg_req.addr - dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR;
    end else if (reg_req.addr >= dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR) begin
      rel = reg_req.addr - dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR;
    end else if (reg_req.addr >= dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR) begin
      rel = reg_req.addr - dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR;
    end else if (reg_req.addr >= dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR) begin
      rel = reg_req.addr - dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR;
    end
  end

  // registered read data, unmapped bytes read zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else if (clock_en) begin
      rdata_reg <= 8'h00;
      if (reg_req.addr >= dpll_core_pkg::AVERAGED_STEP_WORD_ADDR &&
          reg_req.addr < dpll_core_pkg::AVERAGED_STEP_WORD_ADDR + dpll_core_pkg::STEP_BYTES) begin
        rdata_reg <= history_reg[rel[2:0]*8 +: 8];
      end else if (reg_req.addr >= dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR &&
          reg_req.addr < dpll_core_pkg::HISTORY_INTERVAL_MS_ADDR + dpll_core_pkg::INTERVAL_BYTES) begin
        rdata_reg <= interval_reg[rel[1:0]*8 +: 8];
      end else if (reg_req.addr >= dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR &&
          reg_req.addr < dpll_core_pkg::OPEN_LOOP_PHASE_OFFSET_ADDR + dpll_core_pkg::OFFSET_BYTES) begin
        rdata_reg <= offset_reg[rel[0]*8 +: 8];
      end else if (reg_req.addr >= dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR &&
          reg_req.addr < dpll_core_pkg::FREQUENCY_CLAMP_BOUNDS_ADDR + dpll_core_pkg::STEP_BYTES) begin
        rdata_reg <= (rel < dpll_core_pkg::INTERVAL_BYTES) ? clamp_lower_reg[rel[1:0]*8 +: 8]
                                                         : clamp_upper_reg[2'(rel - 12'h3)*8 +: 8];
      end else if (reg_req.addr >= dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR &&
          reg_req.addr < dpll_core_pkg::FREE_RUN_STEP_WORD_ADDR + dpll_core_pkg::STEP_BYTES) begin
        rdata_reg <= free_run_reg[rel[2:0]*8 +: 8];
      end
    end
  end
  assign reg_rdata = rdata_reg;

  // lock detectors: channel 0 phase, channel 1 period difference
  assign open_mode = (loop_mode == dpll_core_pkg::MODE_FREE_RUN) ||
                     (loop_mode == dpll_core_pkg::MODE_HOLDOVER);
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_lock
      logic signed [13:0] level_reg;
      logic signed [13:0] level_next;
      logic [31:0]        mag;
      logic [31:0]        thr;
      logic               vld;
      logic [7:0]         fill;
      logic [7:0]         drain;
      always_comb begin
        vld   = (ch == 0) ? phase_err_valid : period_diff_valid;
        mag   = (ch == 0) ? (phase_err[31] ? 32'(-phase_err) : 32'(phase_err)) // [RULE1]
                          : (period_diff[31] ? 32'(-period_diff) : 32'(period_diff)); // [RULE8]
        thr   = (ch == 0) ? {16'h0, profile.phase_threshold} // [RULE5]
                          : {8'h0, profile.freq_threshold}; // [RULE9]
        fill  = (ch == 0) ? profile.phase_fill : profile.freq_fill; // [RULE4]
        drain = (ch == 0) ? profile.phase_drain : profile.freq_drain; // [RULE4]
        if (mag <= thr) begin
          level_next = level_reg + $signed({6'h0, fill}); // [RULE1]
          if (level_next > dpll_core_pkg::LEVEL_FULL) level_next = dpll_core_pkg::LEVEL_FULL; // [RULE3]
        end else begin
          level_next = level_reg - $signed({6'h0, drain}); // [RULE1]
          if (level_next < dpll_core_pkg::LEVEL_EMPTY) level_next = dpll_core_pkg::LEVEL_EMPTY; // [RULE3]
        end
      end
      // level integration with hysteresis
      always_ff @(posedge clock) begin
        if (!reset_n) begin
          level_reg   <= dpll_core_pkg::LEVEL_EMPTY;
          lock_reg[ch] <= 1'b0;
        end else if (clock_en) begin
          if (open_mode) begin
            level_reg    <= dpll_core_pkg::LEVEL_EMPTY; // [RULE6]
            lock_reg[ch] <= 1'b0; // [RULE6]
          end else if (loop_mode == dpll_core_pkg::MODE_SWITCHOVER) begin
            level_reg <= level_reg; // [RULE7]
          end else if (vld) begin
            level_reg <= level_next;
            if (level_next > dpll_core_pkg::LEVEL_HIGH) lock_reg[ch] <= 1'b1; // [RULE2]
            else if (level_next < dpll_core_pkg::LEVEL_LOW) lock_reg[ch] <= 1'b0; // [RULE2]
          end
        end
      end
      a_level_in_range: assert property (@(posedge clock) disable iff (!reset_n) // [RULE3]
        level_reg <= dpll_core_pkg::LEVEL_FULL && level_reg >= dpll_core_pkg::LEVEL_EMPTY)
        else $error("lock level out of range");
      a_lock_high_mark: assert property (@(posedge clock) disable iff (!reset_n) // [RULE2]
        $rose(lock_reg[ch]) |-> level_reg > dpll_core_pkg::LEVEL_HIGH)
        else $error("lock rose below high mark");
      a_unlock_low_mark: assert property (@(posedge clock) disable iff (!reset_n) // [RULE2]
        $fell(lock_reg[ch]) |-> level_reg < dpll_core_pkg::LEVEL_LOW || $past(open_mode))
        else $error("lock fell above low mark");
    end
  endgenerate
  assign phase_locked = lock_reg[0];
  assign freq_locked  = lock_reg[1];

  a_open_unlock: assert property (@(posedge clock) disable iff (!reset_n) // [RULE6]
    clock_en && open_mode |=> !phase_locked && !freq_locked)
    else $error("lock shown in open loop");
  a_switch_hold: assert property (@(posedge clock) disable iff (!reset_n) // [RULE7]
    clock_en && loop_mode == dpll_core_pkg::MODE_SWITCHOVER |=> $stable(phase_locked))
    else $error("lock changed in switchover");

  // step word source and clamp
  always_comb begin
    case (loop_mode)
      dpll_core_pkg::MODE_FREE_RUN:    selected_word = free_run_reg; // [RULE13]
      dpll_core_pkg::MODE_CLOSED_LOOP: selected_word = loop_filter_word; // [RULE13]
      default:                         selected_word = history_reg; // [RULE13]
    endcase
    clamped_word = selected_word;
    if (selected_word[47:24] > clamp_upper_reg) clamped_word = {clamp_upper_reg, 24'h0}; // [RULE21]
    else if (selected_word[47:24] < clamp_lower_reg) clamped_word = {clamp_lower_reg, 24'h0}; // [RULE21]
  end

  // phase accumulator and offset output
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      accum_reg     <= 48'h0;
      phase_out_reg <= 16'h0;
    end else if (clock_en) begin
      accum_reg     <= accum_reg + clamped_word; // [RULE10]
      phase_out_reg <= accum_reg[47:32] + offset_reg; // [RULE11]
    end
  end
  assign dds_phase = phase_out_reg;

  a_clamp_bound: assert property (@(posedge clock) disable iff (!reset_n) // [RULE14]
    clamped_word[47:24] <= clamp_upper_reg || clamp_upper_reg < clamp_lower_reg)
    else $error("step word above upper bound");
  a_accum_step: assert property (@(posedge clock) disable iff (!reset_n) // [RULE10]
    clock_en |=> accum_reg == 48'($past(accum_reg) + $past(clamped_word)))
    else $error("accumulator step wrong");
  // offset output and clamp range, checked from both bounds
  a_offset_out: assert property (@(posedge clock) disable iff (!reset_n) // [RULE11]
    clock_en |=> dds_phase == 16'($past(accum_reg[47:32]) + $past(offset_reg)))
    else $error("phase offset output wrong");
  a_clamp_low: assert property (@(posedge clock) disable iff (!reset_n) // [RULE14]
    clamped_word[47:24] >= clamp_lower_reg || clamp_upper_reg < clamp_lower_reg)
    else $error("step word below lower bound");
  a_clamp_pass: assert property (@(posedge clock) disable iff (!reset_n) // [RULE21]
    selected_word[47:24] <= clamp_upper_reg && selected_word[47:24] >= clamp_lower_reg
      |-> clamped_word == selected_word)
    else $error("in-range step word altered");

  // history averager over each interval
  logic [31:0] cyc_cnt_reg;
  logic [23:0] ms_cnt_reg;
  logic [87:0] sum_reg;
  logic [39:0] samples_reg;
  logic [87:0] sum_next;
  logic [39:0] samples_next;
  logic        ms_tick;
  logic        interval_end;
  logic        strobe_reg;
  logic        sampling;
  assign sampling     = (loop_mode == dpll_core_pkg::MODE_CLOSED_LOOP);
  assign ms_tick      = (cyc_cnt_reg == 32'(CYCLES_PER_MS - 1));
  assign interval_end = ms_tick && (ms_cnt_reg + 24'h1 >= interval_reg); // [RULE16]
  assign sum_next     = sum_reg + (sampling ? {40'h0, loop_filter_word} : 88'h0); // [RULE22]
  assign samples_next = samples_reg + (sampling ? 40'h1 : 40'h0);
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      cyc_cnt_reg <= 32'h0;
      ms_cnt_reg  <= 24'h0;
      sum_reg     <= 88'h0;
      samples_reg <= 40'h0;
      history_reg <= 48'h0;
      strobe_reg  <= 1'b0;
    end else if (clock_en) begin
      strobe_reg  <= interval_end; // [RULE19]
      cyc_cnt_reg <= ms_tick ? 32'h0 : cyc_cnt_reg + 32'h1;
      if (interval_end) begin
        ms_cnt_reg  <= 24'h0;
        sum_reg     <= 88'h0; // [RULE18]
        samples_reg <= 40'h0; // [RULE18]
        if (samples_next != 40'h0) begin
          history_reg <= 48'(sum_next / {48'h0, samples_next}); // [RULE22]
        end
      end else begin
        ms_cnt_reg  <= ms_tick ? ms_cnt_reg + 24'h1 : ms_cnt_reg;
        sum_reg     <= sum_next;
        samples_reg <= samples_next;
      end
    end
  end

  // history event flag, a new strobe wins over a clear
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      flag_reg <= 1'b0;
    end else if (clock_en) begin
      if (strobe_reg && history_mask_en) flag_reg <= 1'b1; // [RULE19]
      else if (history_flag_clear) flag_reg <= 1'b0;
    end
  end
  assign history_flag   = flag_reg;
  assign history_strobe = strobe_reg;
  assign history_pin    = strobe_reg & history_pin_sel; // [RULE20]

  a_strobe_flag: assert property (@(posedge clock) disable iff (!reset_n) // [RULE19]
    clock_en && strobe_reg && history_mask_en |=> history_flag)
    else $error("history flag not set");
  a_strobe_pulse: assert property (@(posedge clock) disable iff (!reset_n) // [RULE18]
    strobe_reg && clock_en |=> !strobe_reg || CYCLES_PER_MS == 1)
    else $error("history strobe too long");
  a_pin_follow: assert property (@(posedge clock) disable iff (!reset_n) // [RULE20]
    history_pin == (history_strobe && history_pin_sel))
    else $error("pin strobe mismatch");
  a_history_hold: assert property (@(posedge clock) disable iff (!reset_n) // [RULE18]
    clock_en && !interval_end |=> $stable(history_reg))
    else $error("history changed inside interval");
  a_flag_sticky: assert property (@(posedge clock) disable iff (!reset_n) // [RULE19]
    history_flag && !history_flag_clear |=> history_flag)
    else $error("history flag dropped without clear");
endmodule : dpll_tuning_and_lock_core

// [testbench/dpll_tuning_and_lock_core_test.sv]
// self-checking bench for the dpll tuning and lock core
`timescale 1ns/1ps
module dpll_tuning_and_lock_core_test;
  logic                         clock = 1'b0;
  logic                         reset_n = 1'b0;
  logic                         clock_en = 1'b1;
  dpll_core_pkg::reg_req_t      reg_req = '0;
  logic [7:0]                   reg_rdata;
  dpll_core_pkg::loop_mode_t    loop_mode = dpll_core_pkg::MODE_FREE_RUN;
  logic [47:0]                  loop_filter_word = 48'h0;
  dpll_core_pkg::lock_profile_t profile = '{8'hff, 8'hff, 16'h8000, 8'hff, 8'hff, 24'hc00000};
  logic                         phase_err_valid = 1'b0;
  logic signed [31:0]           phase_err = 32'sh0;
  logic                         period_diff_valid = 1'b0;
  logic signed [31:0]           period_diff = 32'sh0;
  logic                         phase_locked;
  logic                         freq_locked;
  logic [15:0]                  dds_phase;
  logic                         history_mask_en = 1'b0;
  logic                         history_flag_clear = 1'b0;
  logic                         history_pin_sel = 1'b0;
  logic                         history_flag;
  logic                         history_strobe;
  logic                         history_pin;
  int                           n_mismatch = 0;
  int                           n_checks = 0;
  int                           cycles = 0;
  int                           gap;

  dpll_tuning_and_lock_core #(.CYCLES_PER_MS(4)) dut (
    .clock(clock), .reset_n(reset_n), .clock_en(clock_en), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .loop_mode(loop_mode), .loop_filter_word(loop_filter_word),
    .profile(profile), .phase_err_valid(phase_err_valid), .phase_err(phase_err),
    .period_diff_valid(period_diff_valid), .period_diff(period_diff),
    .phase_locked(phase_locked), .freq_locked(freq_locked), .dds_phase(dds_phase),
    .history_mask_en(history_mask_en), .history_flag_clear(history_flag_clear),
    .history_pin_sel(history_pin_sel), .history_flag(history_flag),
    .history_strobe(history_strobe), .history_pin(history_pin));

  // 40 mhz clock
  always #12.5 clock = ~clock;

  // cycle ceiling against hangs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [47:0] seen, input logic [47:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // byte write held over one edge; a write left high only repeats the same byte
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_req = '{1'b1, a, d};
    @(posedge clock);
    #2;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    reg_req = '{1'b0, a, 8'h00};
    @(posedge clock);
    #2;
    check("reg_rdata", 48'(reg_rdata), 48'(exp));
  endtask : rd

  // n error samples back to back, then two idle cycles
  task automatic feed(input logic freq, input logic signed [31:0] v, input int n);
    for (int i = 0; i < n; i++) begin
      phase_err_valid = !freq;
      period_diff_valid = freq;
      phase_err = v;
      period_diff = v;
      @(posedge clock);
      #2;
    end
    phase_err_valid = 1'b0;
    period_diff_valid = 1'b0;
    repeat (2) @(posedge clock);
    #2;
  endtask : feed

  // one edge for a new word to reach the accumulator, then one measured edge
  task automatic step(input logic [15:0] exp);
    logic [15:0] a;
    @(posedge clock);
    #2 a = dds_phase;
    @(posedge clock);
    #2;
    check("dds_phase_step", 48'(16'(dds_phase - a)), 48'(exp));
  endtask : step

  task automatic wait_strobe(output int k);
    k = 0;
    do begin
      @(posedge clock);
      #2;
      k++;
    end while (history_strobe !== 1'b1 && k < 20);
    check("history_strobe", 48'(history_strobe), 48'h1);
  endtask : wait_strobe

  // main sequence
  initial begin
    repeat (10) @(posedge clock);
    #2 reset_n = 1'b1;
    for (int i = 0; i < 6; i++) rd(12'h300 + 12'(i), 8'h00);
    for (int i = 0; i < 3; i++) rd(12'h30a + 12'(i), 8'hff);
    rd(12'h307, 8'h00);
    rd(12'h318, 8'h01);
    rd(12'h306, 8'h00);
    wr(12'h300, 8'h11);
    rd(12'h300, 8'h11);
    wr(12'h300, 8'h00);
    wr(12'hd14, 8'h55);
    rd(12'hd14, 8'h00);
    // phase lock fill, freeze, saturation, drain, open mode
    loop_mode = dpll_core_pkg::MODE_CLOSED_LOOP;
    feed(1'b0, -32'sh8000, 12);
    check("phase_locked", 48'(phase_locked), 48'h0);
    feed(1'b0, -32'sh8000, 1);
    check("phase_locked", 48'(phase_locked), 48'h1);
    loop_mode = dpll_core_pkg::MODE_SWITCHOVER;
    feed(1'b0, 32'sh9000, 20);
    check("phase_locked", 48'(phase_locked), 48'h1);
    loop_mode = dpll_core_pkg::MODE_CLOSED_LOOP;
    feed(1'b0, 32'sh8000, 20);
    feed(1'b0, 32'sh8001, 12);
    check("phase_locked", 48'(phase_locked), 48'h1);
    feed(1'b0, -32'sh8001, 1);
    check("phase_locked", 48'(phase_locked), 48'h0);
    feed(1'b0, 32'sh10, 13);
    loop_mode = dpll_core_pkg::MODE_FREE_RUN;
    repeat (2) @(posedge clock);
    #2;
    check("phase_locked", 48'(phase_locked), 48'h0);
    loop_mode = dpll_core_pkg::MODE_CLOSED_LOOP;
    feed(1'b1, -32'sh00c00000, 13);
    check("freq_locked", 48'(freq_locked), 48'h1);
    // synthesizer stepping, offset, freeze and clamp
    loop_mode = dpll_core_pkg::MODE_FREE_RUN;
    wr(12'h304, 8'h01); // test word scaled to one phase count per edge
    step(16'h0001);
    clock_en = 1'b0;
    step(16'h0000);
    clock_en = 1'b1;
    begin
      logic [15:0] a;
      a = dds_phase;
      wr(12'h30e, 8'h10);
      repeat (3) @(posedge clock);
      #2;
      check("dds_phase_offset", 48'(16'(dds_phase - a)), 48'h1004);
    end
    for (int i = 0; i < 3; i++) wr(12'h30a + 12'(i), 8'h00);
    step(16'h0000);
    for (int i = 0; i < 3; i++) wr(12'h30a + 12'(i), 8'hff);
    wr(12'h308, 8'h02);
    step(16'h0002);
    // history averaging, strobe, flag and pin
    loop_mode = dpll_core_pkg::MODE_CLOSED_LOOP;
    loop_filter_word = 48'h0007_1234_5678;
    wait_strobe(gap);
    wait_strobe(gap);
    check("history_pin", 48'(history_pin), 48'h0);
    @(posedge clock);
    #2;
    check("history_flag", 48'(history_flag), 48'h0);
    loop_filter_word = 48'h0003_0000_0000;
    history_mask_en = 1'b1;
    history_pin_sel = 1'b1;
    wait_strobe(gap);
    wait_strobe(gap);
    check("history_strobe_gap", 48'(gap), 48'h4);
    check("history_pin", 48'(history_pin), 48'h1);
    @(posedge clock);
    #2;
    check("history_flag", 48'(history_flag), 48'h1);
    history_flag_clear = 1'b1;
    @(posedge clock);
    #2;
    check("history_flag", 48'(history_flag), 48'h0);
    // clear held high across the next strobe, the set still wins
    wait_strobe(gap);
    @(posedge clock);
    #2 history_flag_clear = 1'b0;
    check("history_flag", 48'(history_flag), 48'h1);
    for (int i = 0; i < 6; i++) rd(12'hd14 + 12'(i), 8'(48'h0003_0000_0000 >> (8 * i)));
    wr(12'h318, 8'h02); // interval kept nonzero
    wait_strobe(gap);
    wait_strobe(gap);
    check("history_strobe_gap", 48'(gap), 48'h8);
    loop_mode = dpll_core_pkg::MODE_HOLDOVER;
    repeat (2) @(posedge clock);
    #2;
    step(16'h0003);
    wrap_up();
  end
endmodule : dpll_tuning_and_lock_core_test
